// ===== hdl/jlic_clkgen.sv
`timescale 1ns/1ps
// frame clock is one mclk per frame (one octet per frame per lane)
module jlic_clkgen
    import jlic_pkg::*;
(
    // clock and reset
    input  wire logic mclk,
    input  wire logic rst,
    // control side
    jlic_clk_if.gen   cif,
    input  wire logic sysref_rise
);
    import jlic_pkg::*;

    logic [4:0] lmfc_cnt_reg;
    logic [4:0] lmfc_cnt_next;
    wire        at_wrap = (lmfc_cnt_reg >= cif.k_m1);
    // lmfc counter restarts on align request
    assign lmfc_cnt_next = cif.align_req ? 5'h00 : (at_wrap ? 5'h00 : lmfc_cnt_reg + 5'h01);
    always_ff @(posedge mclk) begin
        if (rst) lmfc_cnt_reg <= 5'h00;
        else lmfc_cnt_reg <= lmfc_cnt_next;
    end
    assign cif.frame_tick  = 1'b1;
    assign cif.lmfc_tick   = at_wrap;
    // sysref edge expected in the boundary cycle itself (compared with at_wrap, no offset)
    assign cif.lmfc_match  = sysref_rise & at_wrap;
    assign cif.frame_match = 1'b1;
endmodule : jlic_clkgen

// ===== hdl/jlic_link_ctrl.sv
// Chosen here: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
module jlic_link_ctrl
    import jlic_pkg::*;
#(
    parameter int PLL_CAL_LEN  = PLL_CAL_CYCLES,
    parameter int CORE_CAL_LEN = CORE_CAL_CYCLES
) (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst,
    // avalon-mm slave
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // link pins
    input  wire logic        sync_request_n,
    input  wire logic        sysref,
    // sample input
    input  wire logic [15:0] sample,
    // lane outputs
    output logic [7:0]       lane0_data,
    output logic [7:0]       lane1_data,
    output logic             lane_is_k
);
    import jlic_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    jlic_clk_if cif ();
    logic sysref_s1_reg, sysref_s2_reg, sysref_s3_reg;
    logic sync_s1_reg, sync_s2_reg;
    wire  sysref_rise = sysref_s2_reg & ~sysref_s3_reg;
    logic [31:0] ctrl_reg;
    jlic_state_t st_reg, st_next;
    logic [17:0] cal_cnt_reg;
    logic [2:0]  low_cnt_reg;
    logic [1:0]  mf_cnt_reg;
    logic        realigned_reg;
    logic        aligned_reg;
    logic [1:0]  pd_prev_reg;
    logic        pending_core_reg;
    logic [14:0] lfsr_reg;

    jlic_clkgen jlic_clkgen_inst (
        .mclk        (mclk),
        .rst         (rst),
        .cif         (cif),
        .sysref_rise (sysref_rise)
    );

    always_ff @(posedge mclk) begin
        sysref_s1_reg <= sysref;
        sysref_s2_reg <= sysref_s1_reg;
        sysref_s3_reg <= sysref_s2_reg;
        sync_s1_reg   <= sync_request_n;
        sync_s2_reg   <= sync_s1_reg;
    end

    ////////////////////////////////////////////////////////////////////////////
    // configuration and decode
    wire        enable   = ctrl_reg[CTRL_ENABLE_BIT];
    wire        scr_en   = ctrl_reg[CTRL_SCR_BIT];
    wire [4:0]  k_m1_raw = ctrl_reg[CTRL_K_LSB +: 5];
    wire [1:0]  pd_mode  = ctrl_reg[CTRL_PD_LSB +: 2];
    wire [4:0]  k_m1     = (k_m1_raw < K_M1_MIN) ? K_M1_MIN : k_m1_raw;
    wire        sel_ctrl = (avs_address == CTRL_OFS);
    wire        sel_stat = (avs_address == STATUS_OFS);
    wire        req      = avs_read | avs_write;
    assign cif.k_m1 = k_m1;

    // request counted in frame clock, one frame per mclk
    wire sync_low   = ~sync_s2_reg;
    wire sync_valid = (low_cnt_reg >= 3'(SYNC_MIN_FRAMES));
    wire low_hold   = sync_valid | ~cif.frame_tick;
    wire lmfc       = cif.lmfc_tick;
    wire calibrating = (st_reg == JLIC_ST_CORE_CAL) || (st_reg == JLIC_ST_PLL_CAL);
    // frame phase always matches, so a misaligned edge moves the lmfc only
    wire realign = sysref_rise & ~cif.lmfc_match & ~calibrating &
                   (st_reg != JLIC_ST_OFF);
    wire pd_exit_sleep = (pd_prev_reg == PD_SLEEP) && (pd_mode == PD_NORMAL);
    wire pd_exit_down  = (pd_prev_reg == PD_DOWN) && (pd_mode == PD_NORMAL);
    // exit pulse and pending flag race on one edge, so look at both
    wire need_core     = pending_core_reg | pd_exit_down;
    assign cif.align_req = realign | pd_exit_sleep;

    ////////////////////////////////////////////////////////////////////////////
    // avalon slave: one wait cycle, config never touched by power modes
    // write lands at the edge where the master sees waitrequest low
    logic ack_reg;
    always_ff @(posedge mclk) begin
        if (rst) begin
            ack_reg         <= 1'b0;
            avs_waitrequest <= 1'b1;
            ctrl_reg        <= CTRL_RESET;
        end else begin
            ack_reg         <= req & ~ack_reg;
            avs_waitrequest <= ~(req & ~ack_reg);
            if (avs_write & ack_reg & sel_ctrl) ctrl_reg <= avs_writedata;
        end
    end
    wire [31:0] status_word = {20'h00000, 1'b0, realigned_reg, aligned_reg, 1'b0,
                              st_reg == JLIC_ST_DATA, st_reg == JLIC_ST_ILA,
                              st_reg == JLIC_ST_COMMA | st_reg == JLIC_ST_WAIT_LMFC,
                              calibrating, 1'b0, st_reg};
    always_ff @(posedge mclk) begin
        if (rst) avs_readdata <= 32'h00000000;
        else if (avs_read & ~ack_reg) begin
            if (sel_ctrl) avs_readdata <= ctrl_reg;
            else if (sel_stat) avs_readdata <= status_word;
            else avs_readdata <= 32'h00000000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // link state machine
    wire cal_done = (cal_cnt_reg == 18'h00000);
    always_comb begin
        st_next = st_reg;
        case (st_reg)
            JLIC_ST_OFF: begin
                if (enable && pd_mode == PD_NORMAL)
                    st_next = need_core ? JLIC_ST_CORE_CAL : JLIC_ST_PLL_CAL;
            end
            JLIC_ST_CORE_CAL: if (cal_done) st_next = JLIC_ST_PLL_CAL;
            JLIC_ST_PLL_CAL: if (cal_done) st_next = JLIC_ST_COMMA;
            JLIC_ST_COMMA: begin
                if (!sync_low) st_next = JLIC_ST_WAIT_LMFC;
            end
            JLIC_ST_WAIT_LMFC: begin
                if (sync_valid) st_next = JLIC_ST_COMMA;
                else if (lmfc) st_next = JLIC_ST_ILA;
            end
            JLIC_ST_ILA: begin
                if (sync_valid) st_next = JLIC_ST_COMMA;
                else if (lmfc && mf_cnt_reg == 2'(ILA_MFRAMES - 1)) st_next = JLIC_ST_DATA;
            end
            JLIC_ST_DATA: if (sync_valid) st_next = JLIC_ST_COMMA;
            default: st_next = JLIC_ST_OFF;
        endcase
        if (realign && st_reg != JLIC_ST_OFF) st_next = JLIC_ST_PLL_CAL;
        if (!enable || pd_mode != PD_NORMAL) st_next = JLIC_ST_OFF;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            st_reg           <= JLIC_ST_OFF;
            cal_cnt_reg      <= 18'h00000;
            low_cnt_reg      <= 3'h0;
            mf_cnt_reg       <= 2'h0;
            realigned_reg    <= 1'b0;
            aligned_reg      <= 1'b0;
            pd_prev_reg      <= PD_NORMAL;
            pending_core_reg <= 1'b1;
            lfsr_reg         <= 15'h7FFF;
        end else begin
            st_reg      <= st_next;
            pd_prev_reg <= pd_mode;
            if (pd_exit_down) pending_core_reg <= 1'b1;
            else if (st_reg == JLIC_ST_CORE_CAL) pending_core_reg <= 1'b0;
            if (sync_low) low_cnt_reg <= low_hold ? low_cnt_reg : low_cnt_reg + 3'h1;
            else low_cnt_reg <= 3'h0;
            if (st_next == JLIC_ST_CORE_CAL && st_reg != JLIC_ST_CORE_CAL)
                cal_cnt_reg <= 18'(CORE_CAL_LEN - 1);
            else if (st_next == JLIC_ST_PLL_CAL && st_reg != JLIC_ST_PLL_CAL)
                cal_cnt_reg <= 18'(PLL_CAL_LEN - 1);
            else if (!cal_done) cal_cnt_reg <= cal_cnt_reg - 18'h00001;
            if (st_reg != JLIC_ST_ILA) mf_cnt_reg <= 2'h0;
            else if (lmfc) mf_cnt_reg <= mf_cnt_reg + 2'h1;
            if (realign) realigned_reg <= 1'b1;
            // a same-cycle match wins over the sleep-exit clear
            if (pd_exit_sleep) aligned_reg <= 1'b0;
            if (sysref_rise && cif.lmfc_match) aligned_reg <= 1'b1;
            if (st_reg == JLIC_ST_DATA && scr_en)
                lfsr_reg <= {lfsr_reg[13:0], lfsr_reg[14] ^ lfsr_reg[13]};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // lane output; ILA carries K-1 and the scramble flag, never scrambled
    logic [7:0] l0_next, l1_next;
    logic       k_next;
    always_comb begin
        l0_next = K28_5;
        l1_next = K28_5;
        k_next  = 1'b1;
        if (st_reg == JLIC_ST_ILA) begin
            l0_next = (mf_cnt_reg == 2'h1) ? {scr_en, 2'h0, k_m1} : ILA_START;
            l1_next = l0_next;
            k_next  = (mf_cnt_reg != 2'h1);
        end else if (st_reg == JLIC_ST_DATA) begin
            l0_next = sample[15:8] ^ (scr_en ? lfsr_reg[7:0] : 8'h00);
            l1_next = sample[7:0] ^ (scr_en ? lfsr_reg[14:7] : 8'h00);
            k_next  = 1'b0;
        end
    end
    always_ff @(posedge mclk) begin
        if (rst) begin
            lane0_data <= K28_5;
            lane1_data <= K28_5;
            lane_is_k  <= 1'b1;
        end else begin
            lane0_data <= l0_next;
            lane1_data <= l1_next;
            lane_is_k  <= k_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    AST_SHORT_IGNORED: assert property (@(posedge mclk) disable iff (rst)
        (st_reg == JLIC_ST_DATA && low_cnt_reg < 3'h4) |=> st_reg != JLIC_ST_COMMA ||
        $past(sync_valid) || $past(realign))
        else $error("short request broke link");
    AST_DATA_BREAK: assert property (@(posedge mclk) disable iff (rst)
        (st_reg == JLIC_ST_DATA && sync_valid && !realign && enable && pd_mode == PD_NORMAL)
        |=> st_reg == JLIC_ST_COMMA)
        else $error("valid request did not break link");
    AST_REALIGN_BREAK: assert property (@(posedge mclk) disable iff (rst)
        (realign && enable && pd_mode == PD_NORMAL) |=> st_reg == JLIC_ST_PLL_CAL)
        else $error("realign did not restart calibration");
    sequence seq_wait_to_ila;
        st_reg == JLIC_ST_WAIT_LMFC ##1 st_reg == JLIC_ST_ILA;
    endsequence
    sequence seq_ila_to_data;
        st_reg == JLIC_ST_ILA ##1 st_reg == JLIC_ST_DATA;
    endsequence
    AST_ILA_ON_LMFC: assert property (@(posedge mclk) disable iff (rst)
        seq_wait_to_ila |-> $past(lmfc))
        else $error("ILA started off boundary");
    AST_COMMA_OUT: assert property (@(posedge mclk) disable iff (rst)
        (st_reg == JLIC_ST_COMMA) |=> (lane0_data == K28_5 && lane_is_k))
        else $error("no comma during sync");
    AST_DATA_AFTER_ILA: assert property (@(posedge mclk) disable iff (rst)
        seq_ila_to_data |=> !lane_is_k)
        else $error("data not sent after ILA");
    AST_MATCH_NO_ACTION: assert property (@(posedge mclk) disable iff (rst)
        (sysref_rise && cif.lmfc_match && st_reg == JLIC_ST_DATA && !sync_valid &&
         enable && pd_mode == PD_NORMAL) |=> st_reg == JLIC_ST_DATA)
        else $error("matched sysref disturbed link");
    AST_ILA_UNSCRAMBLED: assert property (@(posedge mclk) disable iff (rst)
        (st_reg == JLIC_ST_ILA && mf_cnt_reg == 2'h1) |=> lane0_data[4:0] == k_m1)
        else $error("ILA configuration octet altered");
    AST_DOWN_EXIT_CORE_CAL: assert property (@(posedge mclk) disable iff (rst)
        (st_reg == JLIC_ST_OFF && pd_exit_down && enable) |=> st_reg == JLIC_ST_CORE_CAL)
        else $error("power-down exit skipped core calibration");
    AST_SLEEP_EXIT_PLL_CAL: assert property (@(posedge mclk) disable iff (rst)
        (st_reg == JLIC_ST_OFF && pd_exit_sleep && enable && !pending_core_reg)
        |=> st_reg == JLIC_ST_PLL_CAL)
        else $error("sleep exit did not go to PLL calibration");
    AST_CAL_SENDS_COMMA: assert property (@(posedge mclk) disable iff (rst)
        calibrating |=> (lane_is_k && lane0_data == K28_5 && lane1_data == K28_5))
        else $error("no comma during calibration");
endmodule : jlic_link_ctrl

// ===== inc/jlic_clk_if.sv
`timescale 1ns/1ps
interface jlic_clk_if;
    logic       align_req;
    logic [4:0] k_m1;
    logic       frame_tick;
    logic       lmfc_tick;
    logic       lmfc_match;
    logic       frame_match;
    modport gen (input align_req, input k_m1, output frame_tick, output lmfc_tick,
                 output lmfc_match, output frame_match);
    modport ctl (output align_req, output k_m1, input frame_tick, input lmfc_tick,
                 input lmfc_match, input frame_match);
endinterface : jlic_clk_if

// ===== inc/jlic_pkg.sv
package jlic_pkg;
    // register byte offsets
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    // control fields
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_SCR_BIT    = 1;
    localparam int CTRL_K_LSB      = 8;
    localparam int CTRL_PD_LSB     = 16;
    localparam logic [31:0] CTRL_RESET = 32'h00001F01;
    // frames per multiframe range, stored as k-1
    localparam logic [4:0] K_M1_MIN = 5'h10;
    localparam logic [4:0] K_M1_MAX = 5'h1F;
    // power modes
    localparam logic [1:0] PD_NORMAL = 2'h0;
    localparam logic [1:0] PD_SLEEP  = 2'h1;
    localparam logic [1:0] PD_DOWN   = 2'h2;
    // timing
    localparam int CLK_MHZ        = 100;
    localparam int SYNC_MIN_FRAMES = 4;
    localparam int ILA_MFRAMES     = 4;
    localparam int PLL_CAL_CYCLES  = 153000;
    localparam int CORE_CAL_CYCLES = 1024;
    localparam logic [7:0] K28_5 = 8'hBC;
    localparam logic [7:0] ILA_START = 8'h1C;
    typedef enum logic [2:0] {
        JLIC_ST_OFF, JLIC_ST_CORE_CAL, JLIC_ST_PLL_CAL,
        JLIC_ST_COMMA, JLIC_ST_WAIT_LMFC, JLIC_ST_ILA, JLIC_ST_DATA
    } jlic_state_t;
endpackage : jlic_pkg

// ===== verif/jesd204b_link_init_control_test.sv
`timescale 1ns/1ps
module jesd204b_link_init_control_test;
    import jlic_pkg::*;
    logic        mclk, rst, avs_read, avs_write, avs_waitrequest, sysref, go;
    logic        lane_is_k, sync_request_n;
    logic [7:0]  avs_address, lane0_data, lane1_data;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [3:0]  low_len;
    logic [15:0] sample;
    bit          saw;
    int          mismatches = 0;
    int          tests_run = 0;
    int          cyc = 0;
    int          t0, f0, f1;
    // short calibration counts keep the run brief
    jlic_link_ctrl #(.PLL_CAL_LEN(20), .CORE_CAL_LEN(8)) jlic_link_ctrl_inst (.mclk(mclk),
        .rst(rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .sync_request_n(sync_request_n), .sysref(sysref),
        .sample(sample), .lane0_data(lane0_data), .lane1_data(lane1_data),
        .lane_is_k(lane_is_k));
    jlic_rx_model jlic_rx_model_inst (.mclk(mclk), .rst(rst), .go(go), .low_len(low_len),
        .lane0_data(lane0_data), .lane1_data(lane1_data), .lane_is_k(lane_is_k),
        .sync_request_n(sync_request_n));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk) cyc <= cyc + 1;
    ////////////////////////////////////////////////////////////////////////////////
    task tally_and_finish;
        if (mismatches == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : tally_and_finish
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task bound(input int n, input int lim);
        if (n >= lim) begin
            mismatches++;
            tally_and_finish();
        end
    endtask : bound
    // one avalon transfer, held until waitrequest is sampled low
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        n = 0;
        @(posedge mclk);
        while (avs_waitrequest !== 1'b0 && n < 64) begin
            @(posedge mclk);
            n++;
        end
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        bound(n, 64);
    endtask : bus
    task poll_state(input logic [2:0] s);
        int n;
        saw = 0;
        n = 0;
        do begin
            bus(1'b0, STATUS_OFS, 32'h0);
            if (rd[2:0] === 3'h1) saw = 1;
            n++;
        end while (rd[2:0] !== s && n < 3000);
        bound(n, 3000);
    endtask : poll_state
    task pulse_sync(input logic [3:0] len);
        @(posedge mclk);
        low_len <= len;
        go <= 1'b1;
        @(posedge mclk);
        go <= 1'b0;
    endtask : pulse_sync
    // sequence length is taken from the first /R/ to the first data octet
    task measure_ila(input int k, input bit scr, output int first);
        int n, rc, cc;
        logic [7:0] cfg;
        n = 0;
        rc = 0;
        cc = 0;
        cfg = {scr, 2'h0, 5'(k - 1)};
        @(negedge mclk);
        while (!(lane_is_k === 1'b1 && lane0_data === ILA_START) && n < 3000) begin
            @(negedge mclk);
            n++;
        end
        first = cyc;
        while (n < 3000) begin
            if (lane_is_k === 1'b1 && lane0_data === ILA_START && lane1_data === ILA_START) rc++;
            else if (lane_is_k === 1'b0 && lane0_data === cfg && lane1_data === cfg) cc++;
            else break;
            @(negedge mclk);
            n++;
        end
        bound(n, 3000);
        chk("ila_marker_frames", rc, (ILA_MFRAMES - 1) * k);
        chk("ila_config_frames", cc, k);
        chk("ila_length", cyc - first, ILA_MFRAMES * k);
        repeat (8) @(negedge mclk);
        chk("data_is_k", lane_is_k, 1'b0);
        if (!scr) begin
            chk("data_lane0", lane0_data, sample[15:8]);
            chk("data_lane1", lane1_data, sample[7:0]);
        end
    endtask : measure_ila
    ////////////////////////////////////////////////////////////////////////////////
    task t_reset;
        chk("reset_lane0", lane0_data, K28_5);
        bus(1'b0, CTRL_OFS, 32'h0);
        chk("ctrl_reset", rd, CTRL_RESET);
        bus(1'b1, 8'h08, 32'hFFFFFFFF);
        bus(1'b0, 8'h08, 32'h0);
        chk("unmapped_read", rd, 32'h0);
        bus(1'b0, CTRL_OFS, 32'h0);
        chk("ctrl_after_unmapped", rd, CTRL_RESET);
    endtask : t_reset
    task t_bringup;
        measure_ila(32, 1'b0, f0); // sync stays high, so no request at start
        bus(1'b0, STATUS_OFS, 32'h0);
        chk("status_state", rd[2:0], JLIC_ST_DATA);
        chk("status_data_bit", rd[7], 1'b1);
    endtask : t_bringup
    task t_sync;
        pulse_sync(4'h3);
        repeat (16) @(negedge mclk);
        chk("short_pulse", lane_is_k, 1'b0);
        pulse_sync(4'h6);
        repeat (12) @(negedge mclk);
        chk("comma_k", lane_is_k, 1'b1);
        chk("comma_lane1", lane1_data, K28_5);
        measure_ila(32, 1'b0, f1);
        chk("ila_on_lmfc", (f1 - f0) % 32, 0);
    endtask : t_sync
    task t_kprog;
        bus(1'b1, CTRL_OFS, 32'h00001003);
        bus(1'b0, CTRL_OFS, 32'h0);
        chk("ctrl_k17", rd, 32'h00001003);
        pulse_sync(4'h6);
        measure_ila(17, 1'b1, f0);
    endtask : t_kprog
    task t_power;
        bus(1'b1, CTRL_OFS, 32'h00011001);
        repeat (20) @(posedge mclk);
        bus(1'b1, CTRL_OFS, 32'h00001001);
        poll_state(JLIC_ST_DATA);
        chk("sleep_no_core_cal", saw, 1'b0);
        bus(1'b0, CTRL_OFS, 32'h0);
        chk("ctrl_kept", rd, 32'h00001001);
        bus(1'b1, CTRL_OFS, 32'h00021001);
        repeat (20) @(posedge mclk);
        bus(1'b1, CTRL_OFS, 32'h00001001);
        poll_state(JLIC_ST_DATA);
        chk("down_core_cal", saw, 1'b1);
    endtask : t_power
    task t_sysref;
        int nk;
        pulse_sync(4'h6);
        measure_ila(17, 1'b0, f0);
        // edge lands mid-multiframe, well away from the current lmfc wrap
        do @(posedge mclk); while ((cyc - f0) % 17 != 3);
        t0 = cyc;
        sysref <= 1'b1;
        repeat (4) @(posedge mclk);
        sysref <= 1'b0;
        repeat (12) @(negedge mclk);
        chk("realign_breaks", lane_is_k, 1'b1);
        bus(1'b0, STATUS_OFS, 32'h0);
        chk("realigned_bit", rd[10], 1'b1);
        measure_ila(17, 1'b0, f0);
        // same phase modulo k must match the new lmfc
        t0 = t0 + ((cyc - t0) / 17 + 2) * 17;
        do @(posedge mclk); while (cyc != t0);
        sysref <= 1'b1;
        repeat (4) @(posedge mclk);
        sysref <= 1'b0;
        nk = 0;
        repeat (40) begin
            @(negedge mclk);
            if (lane_is_k !== 1'b0) nk++;
        end
        chk("matched_sysref", nk, 0);
        bus(1'b0, STATUS_OFS, 32'h0);
        chk("aligned_bit", rd[9], 1'b1);
    endtask : t_sysref
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1;
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        sysref = 1'b0;
        go = 1'b0;
        low_len = 4'h0;
        sample = 16'hA55A;
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        @(negedge mclk);
        t_reset();
        t_bringup();
        t_sync();
        t_kprog();
        t_power();
        t_sysref();
        tally_and_finish();
    end
endmodule : jesd204b_link_init_control_test

// ===== verif/jlic_rx_model.sv
`timescale 1ns/1ps
module jlic_rx_model
    import jlic_pkg::*;
(
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       rst,
    // request command
    input  wire logic       go,
    input  wire logic [3:0] low_len,
    // lanes seen
    input  wire logic [7:0] lane0_data,
    input  wire logic [7:0] lane1_data,
    input  wire logic       lane_is_k,
    // sync pin
    output logic            sync_request_n
);
    logic [3:0] low_reg;
    logic [3:0] kcnt_reg;
    // for low_len of four or more, lock only after four commas in a row on both lanes
    wire comma = lane_is_k && lane0_data == K28_5 && lane1_data == K28_5;
    always @(posedge mclk) begin
        if (rst) begin
            sync_request_n <= 1'b1;
            low_reg        <= 4'h0;
            kcnt_reg       <= 4'h0;
        end else if (go) begin
            sync_request_n <= 1'b0;
            low_reg        <= low_len;
            kcnt_reg       <= 4'h0;
        end else if (!sync_request_n) begin
            if (low_reg != 4'h0) low_reg <= low_reg - 4'h1;
            kcnt_reg <= comma ? kcnt_reg + 4'h1 : 4'h0;
            if (low_reg <= 4'h1 && (low_len < 4'h4 || kcnt_reg >= 4'h4)) begin
                sync_request_n <= 1'b1;
            end
        end
    end
endmodule : jlic_rx_model
